/* rtl/interval_timer.sv */
// Purpose: crystal-timed interval counter with control/value registers
// Assumes: XTAL is the 32.768 kHz crystal, asynchronous to CLK (25 MHz)
// Notes:   register writes land on the next crystal edge; SFR_BUSY shows it
`timescale 1ns/1ns
`include "tic_cfg.svh"
module interval_timer (
  input  wire logic        CLK,         // core clock, 25 MHz
  input  wire logic        RST,         // synchronous reset, high
  input  wire logic        CE,          // freezes all state when low
  input  wire logic        XTAL,        // crystal clock pin
  input  wire logic        PWR_DOWN,    // core is in power-down
  input  wire logic        IRQ_EN,      // core enables this interrupt
  input  wire logic [7:0]  SFR_ADDR,    // register address
  input  wire logic [7:0]  SFR_WDATA,   // write data
  input  wire logic        SFR_WR,      // write strobe
  input  wire logic        SFR_RD,      // read strobe
  output logic      [7:0]  SFR_RDATA,   // read data, registered
  output logic             SFR_BUSY,    // write waiting for crystal edge
  output logic             IRQ,         // interrupt request
  output logic             WAKE,        // wake request from power-down
  output logic      [15:0] WAKE_VECTOR  // service vector address
);
  tb_link_if link ();

  logic [2:0]          xsync;
  logic                xtick;
  tic_pkg::wr_state_e  wr_state;
  logic [7:0]          pend_addr;
  logic [7:0]          pend_data;
  logic                apply;
  logic [7:0]          ctrl;
  logic [7:0]          next_ctrl;
  logic [7:0]          ival;
  logic [7:0]          icnt;
  logic [7:0]          next_icnt;
  logic [7:0]          inc;
  logic                sel_ovf;
  logic                match;
  tic_pkg::base_e      sel;

  function automatic logic in_range(input logic [7:0] addr,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = addr >= lo && addr <= hi;
  endfunction

  // crystal pin: two stages, then edge detect on the settled copy
  always_ff @(posedge CLK) begin
    if (RST) begin
      xsync <= 3'h0;
    end else if (CE) begin
      xsync <= {xsync[1:0], XTAL};
    end
  end
  assign xtick = xsync[1] && !xsync[2];

  // one pending write, retired on the next crystal edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_state  <= tic_pkg::WR_IDLE;
      pend_addr <= 8'h00;
      pend_data <= 8'h00;
    end else if (CE) begin
      case (wr_state)
        tic_pkg::WR_IDLE: begin
          if (SFR_WR &&
              in_range(SFR_ADDR, `TIC_ADDR_CTRL, `TIC_ADDR_IVAL)) begin
            pend_addr <= SFR_ADDR;
            pend_data <= SFR_WDATA;
            wr_state  <= tic_pkg::WR_PEND;
          end
        end
        tic_pkg::WR_PEND: begin
          if (xtick) begin
            wr_state <= tic_pkg::WR_IDLE;
          end
        end
        default: wr_state <= tic_pkg::WR_IDLE;
      endcase
    end
  end
  assign SFR_BUSY = wr_state == tic_pkg::WR_PEND;
  assign apply    = SFR_BUSY && xtick;

  // link to the timebase counters
  assign link.xtick  = xtick;
  assign link.run    = ctrl[`TIC_BIT_CEN];
  assign link.h24    = ctrl[`TIC_BIT_H24];
  assign link.ld_en  = apply && !ctrl[`TIC_BIT_CEN] &&
                       in_range(pend_addr, `TIC_ADDR_HTH,
                                `TIC_ADDR_HOUR);
  assign link.ld_sel = 2'(pend_addr - `TIC_ADDR_HTH);
  assign link.ld_val = pend_data;

  time_base u_base (
    .CLK  (CLK),
    .RST  (RST),
    .CE   (CE),
    .link (link)
  );

  assign sel     = tic_pkg::base_e'(ctrl[`TIC_SEL_HI:`TIC_SEL_LO]);
  assign sel_ovf = link.ovf[sel];
  assign inc     = icnt + 8'h01;

  always_comb begin
    next_ctrl = ctrl;
    next_icnt = icnt;
    match     = 1'b0;
    if (apply && pend_addr == `TIC_ADDR_CTRL) begin
      next_ctrl = pend_data & `TIC_CTRL_WMASK;
    end
    if (!ctrl[`TIC_BIT_IEN]) begin
      next_icnt = 8'h00;
    end else if (sel_ovf) begin
      if (inc == ival) begin
        match     = 1'b1;
        next_icnt = 8'h00;
      end else begin
        next_icnt = inc;
      end
    end
    if (match) begin
      // set wins over a clearing write in the same cycle
      next_ctrl[`TIC_BIT_FLAG] = 1'b1;
      if (ctrl[`TIC_BIT_SINGLE]) begin
        next_ctrl[`TIC_BIT_IEN] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= `TIC_CTRL_RESET;
      icnt <= 8'h00;
    end else if (CE) begin
      ctrl <= next_ctrl;
      icnt <= next_icnt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ival <= `TIC_IVAL_RESET;
    end else if (CE && apply && pend_addr == `TIC_ADDR_IVAL) begin
      ival <= pend_data;
    end
  end

  // power-down does not gate any counting state
  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ  <= 1'b0;
      WAKE <= 1'b0;
    end else if (CE) begin
      IRQ  <= ctrl[`TIC_BIT_FLAG] && IRQ_EN;
      WAKE <= ctrl[`TIC_BIT_FLAG] && IRQ_EN && PWR_DOWN;
    end
  end
  assign WAKE_VECTOR = `TIC_VECTOR;

  always_ff @(posedge CLK) begin
    if (RST) begin
      SFR_RDATA <= 8'h00;
    end else if (CE && SFR_RD) begin
      case (SFR_ADDR)
        `TIC_ADDR_CTRL: SFR_RDATA <= ctrl;
        `TIC_ADDR_HTH:  SFR_RDATA <= link.count[0];
        `TIC_ADDR_SEC:  SFR_RDATA <= link.count[1];
        `TIC_ADDR_MIN:  SFR_RDATA <= link.count[2];
        `TIC_ADDR_HOUR: SFR_RDATA <= link.count[3];
        `TIC_ADDR_IVAL: SFR_RDATA <= ival;
        default:        SFR_RDATA <= 8'h00;
      endcase
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  a_write_waits: assert property (CE && SFR_BUSY && !xtick |=> SFR_BUSY)
    else $error("write retired without crystal edge");
  a_count_step: assert property (CE && ctrl[`TIC_BIT_IEN] && sel_ovf &&
    !match |=> icnt == $past(icnt) + 8'h01)
    else $error("interval counter missed a step");
  a_count_hold: assert property (CE && ctrl[`TIC_BIT_IEN] && !sel_ovf
    |=> icnt == $past(icnt))
    else $error("interval counter moved without overflow");
  a_flag_match: assert property (CE && match |=> ctrl[`TIC_BIT_FLAG]
    ##1 (IRQ || !$past(IRQ_EN)))
    else $error("match did not set flag and request");
  a_flag_sticky: assert property (ctrl[`TIC_BIT_FLAG] &&
    !(apply && pend_addr == `TIC_ADDR_CTRL) |=> ctrl[`TIC_BIT_FLAG])
    else $error("match flag cleared by hardware");
  a_wake_vector: assert property (CE && ctrl[`TIC_BIT_FLAG] && IRQ_EN &&
    PWR_DOWN |=> WAKE && WAKE_VECTOR == 16'h0053)
    else $error("no wake from power-down");
  a_single_shot: assert property (CE && match && ctrl[`TIC_BIT_SINGLE]
    |=> !ctrl[`TIC_BIT_IEN] ##1 icnt == 8'h00)
    else $error("single shot did not stop");
  a_auto_reload: assert property (CE && match && !ctrl[`TIC_BIT_SINGLE] &&
    !(apply && pend_addr == `TIC_ADDR_CTRL)
    |=> icnt == 8'h00 && ctrl[`TIC_BIT_IEN])
    else $error("auto reload failed");
  a_idle_zero: assert property (CE && !ctrl[`TIC_BIT_IEN] |=> icnt == 8'h00)
    else $error("disabled counter not held");
  a_no_load_run: assert property (link.ld_en |-> !link.run && apply)
    else $error("time loaded while running");
  a_reserved_zero: assert property (ctrl[`TIC_BIT_RSV] == 1'b0)
    else $error("reserved control bit set");

  // register side: write pending, apply and read back
  a_busy_rise: assert property (CE && !SFR_BUSY && SFR_WR &&
    in_range(SFR_ADDR, `TIC_ADDR_CTRL, `TIC_ADDR_IVAL) |=> SFR_BUSY)
    else $error("accepted write did not raise busy");
  a_busy_drop: assert property (CE && SFR_BUSY && xtick
    |=> !SFR_BUSY)
    else $error("busy stayed up after crystal edge");
  a_busy_quiet: assert property (CE && !SFR_BUSY && !SFR_WR
    |=> !SFR_BUSY)
    else $error("busy rose without a write");
  a_ival_load: assert property (CE && apply &&
    pend_addr == `TIC_ADDR_IVAL |=> ival == $past(pend_data))
    else $error("match value not loaded");
  a_ival_hold: assert property (!(CE && apply &&
    pend_addr == `TIC_ADDR_IVAL) |=> ival == $past(ival))
    else $error("match value changed without a write");
  a_ctrl_load: assert property (CE && apply && !match &&
    pend_addr == `TIC_ADDR_CTRL
    |=> ctrl == ($past(pend_data) & `TIC_CTRL_WMASK))
    else $error("control write not applied");
  a_read_ctrl: assert property (CE && SFR_RD &&
    SFR_ADDR == `TIC_ADDR_CTRL |=> SFR_RDATA == $past(ctrl))
    else $error("control read back wrong");
  a_read_ival: assert property (CE && SFR_RD &&
    SFR_ADDR == `TIC_ADDR_IVAL |=> SFR_RDATA == $past(ival))
    else $error("match value read back wrong");
  a_read_none: assert property (CE && SFR_RD &&
    !in_range(SFR_ADDR, `TIC_ADDR_CTRL, `TIC_ADDR_IVAL)
    |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");

  // request outputs follow the flag one cycle later
  a_irq_follow: assert property (CE
    |=> IRQ == $past(ctrl[`TIC_BIT_FLAG] && IRQ_EN))
    else $error("interrupt request does not follow flag");
  a_wake_follow: assert property (CE
    |=> WAKE == $past(ctrl[`TIC_BIT_FLAG] && IRQ_EN && PWR_DOWN))
    else $error("wake does not follow flag");
  a_wake_awake: assert property (CE && !PWR_DOWN
    |=> !WAKE)
    else $error("wake raised while awake");
  a_pd_count: assert property (CE && PWR_DOWN &&
    ctrl[`TIC_BIT_IEN] && sel_ovf && !match |=> icnt != $past(icnt))
    else $error("interval counter stalled in power-down");
  a_match_cond: assert property (match |->
    ctrl[`TIC_BIT_IEN] && sel_ovf && inc == ival)
    else $error("match without equal count");

  // timebase selection
  a_sel_tick: assert property (ctrl[`TIC_SEL_HI:`TIC_SEL_LO] == 2'h0
    |-> sel_ovf == link.ovf[0])
    else $error("wrong timebase for 1/128 s");
  a_sel_sec: assert property (ctrl[`TIC_SEL_HI:`TIC_SEL_LO] == 2'h1
    |-> sel_ovf == link.ovf[1])
    else $error("wrong timebase for seconds");
  a_sel_min: assert property (ctrl[`TIC_SEL_HI:`TIC_SEL_LO] == 2'h2
    |-> sel_ovf == link.ovf[2])
    else $error("wrong timebase for minutes");
  a_sel_hour: assert property (ctrl[`TIC_SEL_HI:`TIC_SEL_LO] == 2'h3
    |-> sel_ovf == link.ovf[3])
    else $error("wrong timebase for hours");

  // time loads and crystal edges
  a_load_gate: assert property (apply && !ctrl[`TIC_BIT_CEN] &&
    in_range(pend_addr, `TIC_ADDR_HTH, `TIC_ADDR_HOUR) |-> link.ld_en)
    else $error("stopped time load dropped");
  a_run_noload: assert property (ctrl[`TIC_BIT_CEN]
    |-> !link.ld_en)
    else $error("time load while clock enabled");
  a_tick_gap: assert property (CE && xtick
    |=> !xtick)
    else $error("crystal edge lasted two cycles");

  // clock enable low freezes everything
  a_freeze_state: assert property (!CE
    |=> ctrl == $past(ctrl) && icnt == $past(icnt))
    else $error("state moved while frozen");
  a_freeze_out: assert property (!CE
    |=> SFR_RDATA == $past(SFR_RDATA) && IRQ == $past(IRQ))
    else $error("outputs moved while frozen");

  c_match: cover property (match);
  c_single: cover property (match && ctrl[`TIC_BIT_SINGLE]);
  c_wake: cover property (WAKE);
  c_clear_race: cover property (match && apply &&
    pend_addr == `TIC_ADDR_CTRL && !pend_data[`TIC_BIT_FLAG]);
endmodule // interval_timer

/* rtl/tb_link_if.sv */
// Purpose: link between the register side and the timebase counters
// Assumes: one clock; all signals sampled on CLK
// Notes:   count and ovf are indexed by tic_pkg::base_e
`timescale 1ns/1ns
interface tb_link_if;
  logic            xtick;   // one-cycle pulse per crystal edge
  logic            run;     // crystal clock enable
  logic            h24;     // hour counter wraps at 23
  logic            ld_en;   // load a timebase register
  logic [1:0]      ld_sel;  // which timebase register
  logic [7:0]      ld_val;  // value to load
  logic [3:0][7:0] count;   // hundredths, sec, min, hour
  logic [3:0]      ovf;     // increment pulse of each counter

  modport ctl (output xtick, run, h24, ld_en, ld_sel, ld_val,
               input  count, ovf);
  modport base (input  xtick, run, h24, ld_en, ld_sel, ld_val,
                output count, ovf);
endinterface

/* rtl/tic_cfg.svh */
// Purpose: addresses, bit positions, resets and counts of the interval timer
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH

// register addresses in the special-function space
`define TIC_ADDR_CTRL   8'ha1
`define TIC_ADDR_HTH    8'ha2
`define TIC_ADDR_SEC    8'ha3
`define TIC_ADDR_MIN    8'ha4
`define TIC_ADDR_HOUR   8'ha5
`define TIC_ADDR_IVAL   8'ha6

// control register bit positions
`define TIC_BIT_CEN     0
`define TIC_BIT_IEN     1
`define TIC_BIT_FLAG    2
`define TIC_BIT_SINGLE  3
`define TIC_SEL_LO      4
`define TIC_SEL_HI      5
`define TIC_BIT_H24     6
`define TIC_BIT_RSV     7
`define TIC_CTRL_WMASK  8'h7f

// reset values
`define TIC_CTRL_RESET  8'h00
`define TIC_IVAL_RESET  8'h00
`define TIC_TIME_RESET  8'h00

// timing and counter ranges
`define TIC_XTAL_HZ     32768
`define TIC_TICK_HZ     128
`define TIC_PRESCALE    (`TIC_XTAL_HZ / `TIC_TICK_HZ)
`define TIC_HTH_MAX     8'h7f
`define TIC_SEC_MAX     8'h3b
`define TIC_MIN_MAX     8'h3b
`define TIC_H24_MAX     8'h17
`define TIC_HOUR_MAX    8'hff
`define TIC_VECTOR      16'h0053

`endif

/* rtl/tic_pkg.sv */
// Purpose: types shared by the interval timer modules
// Assumes: nothing
// Notes:   encodings of the timebase select follow the control field
package tic_pkg;
  typedef enum logic [1:0] {
    BASE_TICK,
    BASE_SEC,
    BASE_MIN,
    BASE_HOUR
  } base_e;

  typedef enum logic {
    WR_IDLE,
    WR_PEND
  } wr_state_e;
endpackage

/* rtl/time_base.sv */
// Purpose: crystal prescaler and hundredths/seconds/minutes/hours counters
// Assumes: xtick pulses once per crystal period, already synchronised
// Notes:   while stopped the counters mirror the last values written while stopped
`timescale 1ns/1ns
`include "tic_cfg.svh"
module time_base (
  input  wire logic CLK,   // core clock
  input  wire logic RST,   // synchronous reset, high
  input  wire logic CE,    // freezes all state when low
  tb_link_if.base   link   // register-side link
);
  logic [7:0] presc;
  logic [7:0] shadow [4];
  logic [3:0] wrap;

  function automatic logic [7:0] limit_of(input logic [1:0] idx,
                                          input logic       h24);
    case (idx)
      2'h0:    limit_of = `TIC_HTH_MAX;
      2'h1:    limit_of = `TIC_SEC_MAX;
      2'h2:    limit_of = `TIC_MIN_MAX;
      default: limit_of = h24 ? `TIC_H24_MAX : `TIC_HOUR_MAX;
    endcase
  endfunction

  // 256 crystal edges make one 1/128 s step
  assign link.ovf[0] = link.xtick && link.run &&
                       presc == 8'(`TIC_PRESCALE - 1);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wrap[i] = link.count[i] >= limit_of(2'(i), link.h24);
    end
    link.ovf[1] = link.ovf[0] && wrap[0];
    link.ovf[2] = link.ovf[1] && wrap[1];
    link.ovf[3] = link.ovf[2] && wrap[2];
  end

  always_ff @(posedge CLK) begin
    if (RST || (CE && !link.run)) begin
      presc <= 8'h00;
    end else if (CE && link.xtick) begin
      presc <= presc + 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < 4; i++) begin
        shadow[i] <= `TIC_TIME_RESET;
      end
    end else if (CE && link.ld_en) begin
      shadow[link.ld_sel] <= link.ld_val;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      link.count <= {4{`TIC_TIME_RESET}};
    end else if (CE) begin
      for (int i = 0; i < 4; i++) begin
        if (!link.run) begin
          link.count[i] <= shadow[i];
        end else if (link.ovf[i]) begin
          link.count[i] <= wrap[i] ? 8'h00 : link.count[i] + 8'h01;
        end
      end
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  a_sec_wrap: assert property (CE && link.ovf[1] && link.count[1] == 8'h3b
    |=> link.count[1] == 8'h00 && link.count[2] != $past(link.count[2]))
    else $error("seconds did not wrap into minutes");
  a_min_wrap: assert property (CE && link.ovf[2] && link.count[2] == 8'h3b
    |=> link.count[2] == 8'h00)
    else $error("minutes did not wrap at 59");
  a_hour_24: assert property (CE && link.ovf[3] && link.h24 &&
    link.count[3] == 8'h17 |=> link.count[3] == 8'h00)
    else $error("hour did not wrap at 23");
  a_hour_full: assert property (CE && link.ovf[3] && !link.h24 &&
    link.count[3] == 8'h17 |=> link.count[3] == 8'h18)
    else $error("hour wrapped early in full range");
  a_stop_restore: assert property (CE && !link.run && !link.ld_en
    |=> link.count[1] == shadow[1] && link.count[3] == shadow[3])
    else $error("stopped counters not restored");
  a_hth_step: assert property (link.ovf[0] |-> link.run && link.xtick)
    else $error("hundredths step without crystal edge");

  c_hour_wrap: cover property (link.ovf[3] && wrap[3]);
endmodule // time_base

/* tb/interval_timer_tb.sv */
// Purpose: self-checking bench for the crystal-timed interval counter
// Assumes: crystal pin driven at 8 core cycles a period to shorten runs
// Notes:   only the 1/128 s timebase can fire within the run length
`timescale 1ns/1ns
`include "tic_cfg.svh"
module interval_timer_tb;
  logic        CLK;
  logic        RST;
  logic        CE;
  logic        XTAL;
  logic        PWR_DOWN;
  logic        IRQ_EN;
  logic [7:0]  SFR_ADDR;
  logic [7:0]  SFR_WDATA;
  logic        SFR_WR;
  logic        SFR_RD;
  logic [7:0]  SFR_RDATA;
  logic        SFR_BUSY;
  logic        IRQ;
  logic        WAKE;
  logic [15:0] WAKE_VECTOR;
  int          n_errors;
  int          check_count;

  interval_timer i_dut (
    .CLK(CLK), .RST(RST), .CE(CE), .XTAL(XTAL), .PWR_DOWN(PWR_DOWN),
    .IRQ_EN(IRQ_EN), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
    .SFR_BUSY(SFR_BUSY), .IRQ(IRQ), .WAKE(WAKE), .WAKE_VECTOR(WAKE_VECTOR)
  );

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // free-running crystal, phase offset from the core clock
  initial begin
    XTAL = 1'b0;
    #7;
    forever #160 XTAL = ~XTAL;
  end

  task automatic wrap_up;
    $display("errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK) #1;
    SFR_WR = 1'b1;
    SFR_ADDR = a;
    SFR_WDATA = d;
    @(posedge CLK) #1;
    SFR_WR = 1'b0;
    chk("write busy", 16'h0001, {15'h0000, SFR_BUSY});
    while (SFR_BUSY !== 1'b0 && n < 1000) begin
      @(posedge CLK) #1;
      n++;
    end
    if (n >= 1000) begin
      chk("write completion", 16'h0000, 16'h0001);
      wrap_up();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK) #1;
    SFR_RD = 1'b1;
    SFR_ADDR = a;
    @(posedge CLK) #1;
    SFR_RD = 1'b0;
    chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, SFR_RDATA});
  endtask

  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    while (IRQ !== 1'b1 && n < bound) begin
      @(posedge CLK) #1;
      n++;
    end
    if (n >= bound) begin
      chk("interrupt timeout", 16'h0000, 16'h0001);
      wrap_up();
    end
  endtask

  task automatic t_reset_values;
    rd(`TIC_ADDR_CTRL, 8'h00);
    rd(`TIC_ADDR_IVAL, 8'h00);
    rd(`TIC_ADDR_HTH, 8'h00);
    rd(`TIC_ADDR_HOUR, 8'h00);
    wr(`TIC_ADDR_CTRL, 8'h80);
    rd(`TIC_ADDR_CTRL, 8'h00);
    rd(8'ha0, 8'h00);
    chk("vector", 16'h0053, WAKE_VECTOR);
  endtask

  // time loaded just short of a 24-hour rollover, then two ticks run in each hour mode
  task automatic t_time_roll;
    for (int i = 0; i < 2; i++) begin
      wr(`TIC_ADDR_CTRL, 8'h00);
      wr(`TIC_ADDR_HTH, 8'h7e);
      wr(`TIC_ADDR_SEC, 8'h3b);
      wr(`TIC_ADDR_MIN, 8'h3b);
      wr(`TIC_ADDR_HOUR, 8'h17);
      wr(`TIC_ADDR_CTRL, (i == 0) ? 8'h41 : 8'h01);
      wr(`TIC_ADDR_SEC, 8'h11);
      repeat (4600) @(posedge CLK);
      #1;
      rd(`TIC_ADDR_HTH, 8'h00);
      rd(`TIC_ADDR_SEC, 8'h00);
      rd(`TIC_ADDR_MIN, 8'h00);
      rd(`TIC_ADDR_HOUR, (i == 0) ? 8'h00 : 8'h18);
      wr(`TIC_ADDR_CTRL, 8'h00);
      rd(`TIC_ADDR_HTH, 8'h7e);
      rd(`TIC_ADDR_SEC, 8'h3b);
    end
  endtask

  task automatic t_auto_reload;
    PWR_DOWN = 1'b1;
    IRQ_EN = 1'b1;
    wr(`TIC_ADDR_IVAL, 8'h02);
    rd(`TIC_ADDR_IVAL, 8'h02);
    wr(`TIC_ADDR_CTRL, 8'h03);
    wait_irq(6000);
    @(posedge CLK) #1;
    chk("wake", 16'h0001, {15'h0000, WAKE});
    rd(`TIC_ADDR_CTRL, 8'h07);
    repeat (4400) @(posedge CLK);
    #1;
    rd(`TIC_ADDR_CTRL, 8'h07);
    wr(`TIC_ADDR_CTRL, 8'h03);
    repeat (2) @(posedge CLK);
    #1;
    chk("irq after clear", 16'h0000, {15'h0000, IRQ});
    wait_irq(4400);
    PWR_DOWN = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk("wake awake", 16'h0000, {15'h0000, WAKE});
    IRQ_EN = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk("irq masked", 16'h0000, {15'h0000, IRQ});
    wr(`TIC_ADDR_CTRL, 8'h00);
  endtask

  task automatic t_single_shot;
    IRQ_EN = 1'b1;
    wr(`TIC_ADDR_IVAL, 8'h01);
    wr(`TIC_ADDR_CTRL, 8'h0b);
    wait_irq(2600);
    rd(`TIC_ADDR_CTRL, 8'h0d);
    wr(`TIC_ADDR_CTRL, 8'h00);
  endtask

  // counter disabled or slow timebase: nothing may fire in two ticks
  task automatic t_no_match;
    logic [7:0] cfg [4] = '{8'h01, 8'h13, 8'h23, 8'h33};
    logic       seen;
    wr(`TIC_ADDR_HTH, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`TIC_ADDR_CTRL, cfg[i]);
      seen = 1'b0;
      for (int n = 0; n < 5000; n++) begin
        @(posedge CLK) #1;
        if (IRQ !== 1'b0) begin
          seen = 1'b1;
        end
      end
      chk("irq stays low", 16'h0000, {15'h0000, seen});
      rd(`TIC_ADDR_CTRL, cfg[i]);
      wr(`TIC_ADDR_CTRL, 8'h00);
    end
  endtask

  // write strobe while clock enable is low must not be taken
  task automatic t_freeze;
    @(posedge CLK) #1;
    CE = 1'b0;
    SFR_WR = 1'b1;
    SFR_ADDR = `TIC_ADDR_IVAL;
    SFR_WDATA = 8'h55;
    @(posedge CLK) #1;
    SFR_WR = 1'b0;
    CE = 1'b1;
    chk("frozen busy", 16'h0000, {15'h0000, SFR_BUSY});
    rd(`TIC_ADDR_IVAL, 8'h01);
  endtask

  initial begin
    n_errors = 0;
    check_count = 0;
    RST = 1'b1;
    CE = 1'b1;
    PWR_DOWN = 1'b0;
    IRQ_EN = 1'b0;
    SFR_ADDR = 8'h00;
    SFR_WDATA = 8'h00;
    SFR_WR = 1'b0;
    SFR_RD = 1'b0;
    repeat (10) @(posedge CLK);
    #1;
    RST = 1'b0;
    @(posedge CLK) #1;
    t_reset_values();
    t_time_roll();
    t_auto_reload();
    t_single_shot();
    t_no_match();
    t_freeze();
    wrap_up();
  end
endmodule // interval_timer_tb
